// *** verilog/nv_guard_pkg.sv ***
// shared constants and types for the data eeprom write guard
package nv_guard_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_PERIPHERAL_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_NV_DATA          = 8'h9A;
    localparam logic [7:0] IDX_NV_ADDRESS       = 8'h9B;
    localparam logic [7:0] IDX_NV_CONTROL       = 8'h9C;
    localparam logic [7:0] IDX_NV_UNLOCK        = 8'h9D;
    localparam logic [7:0] IDX_IRQ_STATUS       = 8'hA0;
    localparam logic [7:0] IDX_IRQ_MASK         = 8'hA1;
    localparam logic [7:0] IDX_NV_CONFIG        = 8'hA2;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_RD_BIT      = 0;
    localparam int CTRL_WR_BIT      = 1;
    localparam int CTRL_GUARD_BIT   = 2;
    localparam int CTRL_WRITE_ERROR_FLAG_BIT   = 3;
    localparam int FLAGS_DONE_BIT   = 7;
    localparam int IRQ_DONE_BIT     = 0;
    localparam int IRQ_ERR_BIT      = 1;
    localparam int IRQ_BITS         = 2;
    localparam int CFG_PROTECT_BIT  = 0;
    localparam logic CFG_PROTECT_RST = 1'b1;   // erased config bit: unprotected
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [1:0] MASK_RST = 2'h0;

    // ------------------------------------------------------------------
    // array geometry and unlock keys
    // ------------------------------------------------------------------
    localparam int NV_AW = 7;
    localparam int NV_DEPTH = 128;
    localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 25;
    localparam int CLK_KHZ         = 40000;
    localparam int PWRT_TIME_MS    = 72;
    localparam int PWRT_CYCLES_DEF = PWRT_TIME_MS * CLK_KHZ;
    localparam int WR_TIME_NS      = 4000;
    localparam int WR_CYCLES       = (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRT_CW         = 22;
    localparam int WR_CW           = 8;

    // one array programming command
    typedef struct packed {
        logic [NV_AW-1:0] addr;
        logic [7:0]       data;
    } nv_wr_cmd_t;

    typedef enum logic [1:0] {
        UNLOCK_IDLE,
        UNLOCK_GOT_FIRST,
        UNLOCK_ARMED
    } unlock_state_t;

endpackage : nv_guard_pkg

// *** verilog/nv_unlock_seq.sv ***
// unlock key sequence tracker for the write port
`timescale 1ns/1ps
module nv_unlock_seq
    import nv_guard_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // taken bus accesses
    input  wire logic       acc,
    input  wire logic       unlock_wr,
    input  wire logic [7:0] wdata,
    // armed for one control write
    output logic            armed
);

    unlock_state_t state_q;

    // any access other than the expected next one drops the sequence,
    // so stray code between the keys can never start a write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= UNLOCK_IDLE;
        else if (ce && acc)
        begin
            unique case (state_q)
                UNLOCK_IDLE:
                    state_q <= (unlock_wr && wdata == UNLOCK_KEY_FIRST) ?
                               UNLOCK_GOT_FIRST : UNLOCK_IDLE;
                UNLOCK_GOT_FIRST:
                    state_q <= (unlock_wr && wdata == UNLOCK_KEY_SECOND) ?
                               UNLOCK_ARMED : UNLOCK_IDLE;
                UNLOCK_ARMED:
                    state_q <= (unlock_wr && wdata == UNLOCK_KEY_FIRST) ?
                               UNLOCK_GOT_FIRST : UNLOCK_IDLE;
                default:
                    state_q <= UNLOCK_IDLE;
            endcase
        end
    end

    assign armed = (state_q == UNLOCK_ARMED);

endmodule : nv_unlock_seq

// *** verilog/nv_cell_array.sv ***
// 128 byte cell array with its programming timer
`timescale 1ns/1ps
module nv_cell_array
    import nv_guard_pkg::*;
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // programming
    input  wire logic             start,
    input  wire nv_wr_cmd_t       cmd,
    output logic                  busy,
    output logic                  done,
    // read port
    input  wire logic [NV_AW-1:0] rd_addr,
    output logic [7:0]            rd_data
);

    logic [7:0]       cells [NV_DEPTH];
    nv_wr_cmd_t       cmd_q;
    logic [WR_CW-1:0] cnt_q;
    logic             busy_q;
    logic             done_q;

    // latch the command so software may change address and data mid-write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q  <= '0;
            cmd_q  <= '0;
        end
        else if (ce)
        begin
            done_q <= 1'b0;
            if (start && !busy_q)
            begin
                busy_q <= 1'b1;
                cnt_q  <= WR_CW'(WR_CYCLES - 1);
                cmd_q  <= cmd;
            end
            else if (busy_q)
            begin
                if (cnt_q == '0)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                else
                    cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // cells keep their content across reset, as a nonvolatile array would
    always_ff @(posedge pclk)
    begin
        if (ce && busy_q && cnt_q == '0)
            cells[cmd_q.addr] <= cmd_q.data;
    end

    assign rd_data = cells[rd_addr];
    assign busy    = busy_q;
    assign done    = done_q;

endmodule : nv_cell_array

// *** verilog/eeprom_write_guard.sv ***
// data eeprom control, write guard and apb register file
//
// Behaviour
// - power-up clears the write enable guard
// - no write while power-up timer runs
// - write needs guard set and unlock done
// - config bit zero means data protected
// - protection never restricts cpu read or write
// - unlock port has no storage, reads zero
// - keys 55h then AAh then start bit
// - start ignored without guard; no mid-write abort
// - write end clears start, sets complete flag
// - read bit loads data next cycle, self-clears
`timescale 1ns/1ps
module eeprom_write_guard
    import nv_guard_pkg::*;
#(
    parameter int unsigned PWRT_CYCLES = PWRT_CYCLES_DEF
)
(
    // clock, reset and enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // status
    output logic             irq,
    output logic             data_protected,
    output logic             write_busy
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic                pready_q;
    logic                pslverr_q;
    logic [31:0]         prdata_q;
    logic [31:0]         prdata_d;
    logic                mapped_d;
    logic [7:0]          data_q;
    logic [NV_AW-1:0]    addr_q;
    logic                guard_q;
    logic                wr_q;
    logic                rd_q;
    logic                write_error_flag_q;
    logic                done_flag_q;
    logic [IRQ_BITS-1:0] irq_stat_q;
    logic [IRQ_BITS-1:0] irq_mask_q;
    logic [IRQ_BITS-1:0] irq_event;
    logic                cfg_protect_q;
    logic                prot_q;
    logic                irq_q;
    logic                busy_q;
    logic [PWRT_CW-1:0]  pwrt_cnt_q;
    logic                pwrt_done_q;
    logic                armed;
    logic                arr_busy;
    logic                arr_done;
    logic [7:0]          arr_rdata;
    nv_wr_cmd_t          wr_cmd;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic [7:0] idx;
    logic       acc;
    logic       wr_acc;
    logic       rd_acc;
    logic       ctrl_wr;
    logic       start_req;
    logic       start;

    assign idx     = paddr[9:2];
    assign acc     = ce && psel && penable && pready_q;
    assign wr_acc  = acc && pwrite;
    assign rd_acc  = acc && !pwrite;
    assign ctrl_wr = wr_acc && idx == IDX_NV_CONTROL;
    assign start_req = ctrl_wr && pwdata[CTRL_WR_BIT] && !wr_q;
    // the guard, the unlock keys and the power-up timer must all agree
    assign start = start_req && guard_q && armed && pwrt_done_q;

    // read mux, captured one cycle before the access completes
    always_comb
    begin
        prdata_d = 32'h0000_0000;
        mapped_d = paddr[11:10] == 2'h0;
        unique case (idx)
            IDX_PERIPHERAL_FLAGS: prdata_d[FLAGS_DONE_BIT] = done_flag_q;
            IDX_NV_DATA:          prdata_d[7:0] = data_q;
            IDX_NV_ADDRESS:       prdata_d[NV_AW-1:0] = addr_q;
            IDX_NV_CONTROL:
            begin
                prdata_d[CTRL_RD_BIT]    = rd_q;
                prdata_d[CTRL_WR_BIT]    = wr_q;
                prdata_d[CTRL_GUARD_BIT] = guard_q;
                prdata_d[CTRL_WRITE_ERROR_FLAG_BIT] = write_error_flag_q;
            end
            IDX_NV_UNLOCK:        prdata_d = 32'h0000_0000;
            IDX_IRQ_STATUS:       prdata_d[IRQ_BITS-1:0] = irq_stat_q;
            IDX_IRQ_MASK:         prdata_d[IRQ_BITS-1:0] = irq_mask_q;
            IDX_NV_CONFIG:        prdata_d[CFG_PROTECT_BIT] = cfg_protect_q;
            default:              mapped_d = 1'b0;
        endcase
    end

    // one wait state: pready rises on the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped_d;
            if (psel && penable && !pready_q && !pwrite && mapped_d)
                prdata_q <= prdata_d;
            else if (pready_q)
                prdata_q <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // power-up timer
    // ------------------------------------------------------------------
    // counts only while enabled, so a frozen block also freezes the window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwrt_cnt_q  <= '0;
            pwrt_done_q <= 1'b0;
        end
        else if (ce && !pwrt_done_q)
        begin
            pwrt_cnt_q <= pwrt_cnt_q + 1'b1;
            if (pwrt_cnt_q == PWRT_CW'(PWRT_CYCLES - 1))
                pwrt_done_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // address, data and configuration
    // ------------------------------------------------------------------
    // data register: software write, or read result on the following cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            data_q <= DATA_RST;
        else if (ce)
        begin
            if (rd_q)
                data_q <= arr_rdata;
            else if (wr_acc && idx == IDX_NV_DATA)
                data_q <= pwdata[7:0];
        end
    end

    // address and configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_q        <= ADDR_RST;
            cfg_protect_q <= CFG_PROTECT_RST;
            prot_q        <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_acc && idx == IDX_NV_ADDRESS)
                addr_q <= pwdata[NV_AW-1:0];
            if (wr_acc && idx == IDX_NV_CONFIG)
                cfg_protect_q <= pwdata[CFG_PROTECT_BIT];
            prot_q <= !cfg_protect_q;
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    // read and start bits can only be set by software; hardware clears them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            guard_q <= 1'b0;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            write_error_flag_q <= 1'b0;
            busy_q  <= 1'b0;
        end
        else if (ce)
        begin
            rd_q   <= ctrl_wr && pwdata[CTRL_RD_BIT];
            busy_q <= arr_busy || start;
            if (ctrl_wr)
                guard_q <= pwdata[CTRL_GUARD_BIT];
            if (start)
                wr_q <= 1'b1;
            else if (arr_done)
                wr_q <= 1'b0;
            // a refused attempt with the guard set sets the error flag
            if (start_req && guard_q && !start)
                write_error_flag_q <= 1'b1;
            else if (ctrl_wr)
                write_error_flag_q <= pwdata[CTRL_WRITE_ERROR_FLAG_BIT];
        end
    end

    // write complete flag: set wins over a software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_flag_q <= 1'b0;
        else if (ce)
        begin
            if (arr_done)
                done_flag_q <= 1'b1;
            else if (wr_acc && idx == IDX_PERIPHERAL_FLAGS)
                done_flag_q <= pwdata[FLAGS_DONE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    assign irq_event[IRQ_DONE_BIT] = arr_done;
    assign irq_event[IRQ_ERR_BIT]  = start_req && guard_q && !start;

    // a read clears only bits it returned, so a fresh event is never lost
    generate
        for (genvar b = 0; b < IRQ_BITS; b++)
        begin : g_irq
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    irq_stat_q[b] <= 1'b0;
                else if (ce)
                begin
                    if (irq_event[b])
                        irq_stat_q[b] <= 1'b1;
                    else if (rd_acc && idx == IDX_IRQ_STATUS && prdata_q[b])
                        irq_stat_q[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // mask register and the registered interrupt line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask_q <= MASK_RST;
            irq_q      <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_acc && idx == IDX_IRQ_MASK)
                irq_mask_q <= pwdata[IRQ_BITS-1:0];
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    assign wr_cmd.addr = addr_q;
    assign wr_cmd.data = data_q;

    nv_unlock_seq u_unlock (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .acc       (acc),
        .unlock_wr (wr_acc && idx == IDX_NV_UNLOCK),
        .wdata     (pwdata[7:0]),
        .armed     (armed)
    );

    nv_cell_array u_array (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .start   (start),
        .cmd     (wr_cmd),
        .busy    (arr_busy),
        .done    (arr_done),
        .rd_addr (addr_q),
        .rd_data (arr_rdata)
    );

    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign prdata         = prdata_q;
    assign irq            = irq_q;
    assign data_protected = prot_q;
    assign write_busy     = busy_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    guard_after_reset_a: assert property ($rose(presetn) |-> !guard_q)
        else $error("guard set straight after reset");
    pwrt_blocks_start_a: assert property (!pwrt_done_q |-> !start)
        else $error("write started inside power-up window");
    start_needs_all_a: assert property (start |-> guard_q && armed && pwrt_done_q)
        else $error("write started without guard or unlock");
    protect_tracks_cfg_a: assert property
        (ce ##1 ce |-> prot_q == !$past(cfg_protect_q))
        else $error("protect output does not follow config bit");
    start_runs_write_a: assert property (start |=> wr_q && arr_busy)
        else $error("accepted start did not begin a write");
    guard_clear_ignored_a: assert property (ctrl_wr && !guard_q && !wr_q |=> !wr_q)
        else $error("start bit set with guard clear");
    done_sets_flags_a: assert property (ce && arr_done |=> !wr_q && done_flag_q)
        else $error("write end did not clear start and set flag");
    read_loads_data_a: assert property
        (ce && rd_q |=> !rd_q && data_q == $past(arr_rdata))
        else $error("read did not load data register next cycle");
    unlock_reads_zero_a: assert property
        ($rose(pready_q) && !pwrite && idx == IDX_NV_UNLOCK |-> prdata_q == 32'h0000_0000)
        else $error("unlock port returned data");
    addr_top_zero_a: assert property
        ($rose(pready_q) && !pwrite && idx == IDX_NV_ADDRESS |-> prdata_q[31:7] == '0)
        else $error("address register top bits not zero");
    prot_write_ok_a: assert property (prot_q && start |=> wr_q)
        else $error("protection blocked a write");

    write_start_c: cover property (start);
    write_done_c: cover property (arr_done ##2 irq_q);
    read_cycle_c: cover property (rd_q ##1 prot_q);

endmodule : eeprom_write_guard

// *** testbench/tb.sv ***
// self-checking bench for the data eeprom write guard
`timescale 1ns/1ps
module tb;
    import nv_guard_pkg::*;

    // ------------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------------
    localparam int PWRT = 40;           // short power-up timer for simulation
    logic        pclk, presetn, ce, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, irq, data_protected, write_busy;
    logic [32:0] q[$];                  // expected {pslverr, prdata} per access
    int          n_errors, tests_run, seed, cycles, busy_n, frz;
    logic [6:0]  a[4];
    logic [7:0]  d[4];

    eeprom_write_guard #(.PWRT_CYCLES(PWRT)) uut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .irq(irq),
        .data_protected(data_protected), .write_busy(write_busy));

    // ------------------------------------------------------------------
    // clock, timeout, busy length and response monitor
    // ------------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ceiling well above the roughly 1300 cycles the sequence needs
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            summarize();
        end
    end

    always @(negedge pclk)
        if (write_busy === 1'b1)
            busy_n++;

    // pready stands one cycle, so the falling edge sees each answer once
    always @(negedge pclk)
        if (pready === 1'b1 && psel === 1'b1 && q.size() > 0)
            cmp_rd({pslverr, prdata}, q.pop_front());

    // ------------------------------------------------------------------
    // compare, bus and report tasks
    // ------------------------------------------------------------------
    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_rd({32'h0, got}, {32'h0, exp});
    endtask : cmp_bit

    // one idle cycle between accesses keeps each signal to one driver step
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       input logic [32:0] exp);
        q.push_back(exp);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is taken at the very rising edge at which the access completes
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // upper data bits carry noise that the registers must ignore
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b1, idx, {24'($random(seed)), v}, 33'h0);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [32:0] e);
        apb(1'b0, idx, 32'h0, e);
    endtask : rd

    task automatic unlock(input logic [7:0] start);
        wr(IDX_NV_UNLOCK, UNLOCK_KEY_FIRST);
        wr(IDX_NV_UNLOCK, UNLOCK_KEY_SECOND);
        wr(IDX_NV_CONTROL, start);
    endtask : unlock

    task automatic settle();
        repeat (2) @(negedge pclk);
    endtask : settle

    task automatic wait_done();
        int k;
        k = 0;
        while (write_busy !== 1'b0 && k < 400)
        begin
            @(negedge pclk);
            k++;
        end
        cmp_bit(write_busy, 1'b0);
    endtask : wait_done

    task automatic summarize();
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        seed = 6;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_errors = 0;
        tests_run = 0;
        cycles = 0;
        busy_n = 0;
        frz = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // full unlock while the power-up timer still runs
        rd(IDX_NV_CONTROL, 33'h0);
        wr(IDX_NV_CONTROL, 8'h04);
        unlock(8'h06);
        settle();
        cmp_bit(write_busy, 1'b0);
        rd(IDX_NV_CONTROL, 33'h0C);
        repeat (PWRT) @(posedge pclk);
        rd(IDX_IRQ_STATUS, 33'h2);
        rd(IDX_IRQ_STATUS, 33'h0);
        cmp_bit(irq, 1'b0);
        cmp_bit(data_protected, 1'b0);
        rd(IDX_NV_CONFIG, 33'h1);
        rd(IDX_IRQ_MASK, 33'h0);
        rd(IDX_NV_DATA, 33'h0);
        rd(IDX_NV_ADDRESS, 33'h0);
        // start with the guard clear is dropped silently
        wr(IDX_NV_CONTROL, 8'h00);
        unlock(8'h02);
        rd(IDX_NV_CONTROL, 33'h0);
        // broken key orders: swapped, read between, write between
        for (int v = 0; v < 3; v++)
        begin
            wr(IDX_NV_CONTROL, 8'h04);
            wr(IDX_NV_UNLOCK, (v == 0) ? UNLOCK_KEY_SECOND : UNLOCK_KEY_FIRST);
            if (v == 1)
                rd(IDX_NV_DATA, 33'h0);
            wr(IDX_NV_UNLOCK, (v == 0) ? UNLOCK_KEY_FIRST : UNLOCK_KEY_SECOND);
            if (v == 2)
                wr(IDX_NV_ADDRESS, 8'h00);
            wr(IDX_NV_CONTROL, 8'h06);
            cmp_bit(write_busy, 1'b0);
            rd(IDX_NV_CONTROL, 33'h0C);
            rd(IDX_IRQ_STATUS, 33'h2);
            wr(IDX_NV_CONTROL, 8'h00);
        end
        // good writes, protection toggled, guard dropped mid-write
        wr(IDX_IRQ_MASK, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            a[i] = {i[1:0], (i == 3) ? 5'h1F : 5'($random(seed))};
            d[i] = 8'($random(seed));
            wr(IDX_NV_CONFIG, {7'h0, ~i[0]});
            settle();
            cmp_bit(data_protected, i[0]);
            wr(IDX_NV_ADDRESS, {1'b0, a[i]});
            wr(IDX_NV_DATA, d[i]);
            wr(IDX_NV_CONTROL, 8'h04);
            busy_n = 0;
            unlock(8'h06);
            settle();
            cmp_bit(write_busy, 1'b1);
            // freeze the block mid-write: the write must stretch, not abort
            frz = (i == 3) ? 50 : 0;
            if (frz > 0)
            begin
                @(posedge pclk);
                ce <= 1'b0;
                repeat (frz) @(posedge pclk);
                ce <= 1'b1;
            end
            wr(IDX_NV_CONTROL, 8'h00);
            cmp_bit(write_busy, 1'b1);
            wait_done();
            cmp_bit(busy_n >= WR_CYCLES - 1 + frz && busy_n <= WR_CYCLES + 1 + frz, 1'b1);
            settle();
            cmp_bit(irq, 1'b1);
            rd(IDX_NV_CONTROL, 33'h0);
            rd(IDX_PERIPHERAL_FLAGS, 33'h80);
            rd(IDX_IRQ_STATUS, 33'h1);
            settle();
            cmp_bit(irq, 1'b0);
            rd(IDX_PERIPHERAL_FLAGS, 33'h80);
            wr(IDX_PERIPHERAL_FLAGS, 8'h00);
            rd(IDX_PERIPHERAL_FLAGS, 33'h0);
        end
        // read back every written byte
        for (int i = 0; i < 4; i++)
        begin
            wr(IDX_NV_ADDRESS, {1'b0, a[i]});
            wr(IDX_NV_CONTROL, 8'h01);
            rd(IDX_NV_CONTROL, 33'h0);
            rd(IDX_NV_DATA, {25'h0, d[i]});
        end
        // register corners and unmapped places
        wr(IDX_NV_ADDRESS, 8'hFF);
        rd(IDX_NV_ADDRESS, 33'h7F);
        wr(IDX_NV_DATA, 8'h3C);
        rd(IDX_NV_DATA, 33'h3C);
        wr(IDX_NV_UNLOCK, 8'h5A);
        rd(IDX_NV_UNLOCK, 33'h0);
        rd(8'h50, {1'b1, 32'h0});
        apb(1'b1, 8'h51, 32'h0000_00FF, {1'b1, 32'h0});
        // a second power-up clears the guard and restarts the timer
        wr(IDX_NV_CONTROL, 8'h04);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_NV_CONTROL, 33'h0);
        wr(IDX_NV_CONTROL, 8'h04);
        unlock(8'h06);
        rd(IDX_NV_CONTROL, 33'h0C);
        settle();
        summarize();
    end

endmodule : tb
